/* design/flash_status_host.sv */
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "flash_poll_cfg.svh"
module flash_status_host #(
   parameter int       AW        = 19,
   parameter int       STROBE    = `STROBE_CYC,
   parameter bit [7:0] RESET_CMD = 8'hF0
) (
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic [4:0]    awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic     [1:0]     bresp,
   output logic               bvalid,
   input  wire logic          bready,
   input  wire logic [4:0]    araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic     [31:0]    rdata,
   output logic     [1:0]     rresp,
   output logic               rvalid,
   input  wire logic          rready,
   output logic     [AW-1:0]  flash_addr,
   output logic     [7:0]     flash_dq_out,
   output logic               flash_dq_oe,
   input  wire logic [7:0]    flash_dq_in,
   output logic               flash_ce_n,
   output logic               flash_oe_n,
   output logic               flash_we_n,
   input  wire logic          ready_busy_n_out
);
   logic          awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
   logic [1:0]    bresp_next, rresp_next;
   logic [31:0]   rdata_next;
   logic [AW-1:0] addr_reg, addr_next;
   logic [7:0]    wdata_reg, wdata_next;
   logic [1:0]    op_reg, op_next;
   logic          go_reg, go_next, abort_reg, abort_next;
   logic          wr_take;

   flash_poll_pkg::state_e st_reg, st_next;
   logic       cyc_start_reg, cyc_start_next, cyc_wr_reg, cyc_wr_next;
   logic [7:0] cyc_data_reg, cyc_data_next;
   logic [7:0] first_reg, first_next, last_reg, last_next;
   logic       ok_reg, ok_next, fail_reg, fail_next, rej_reg, rej_next;
   logic       rb_reg;
   logic [7:0] cyc_rdata;
   logic       cyc_done;

   flash_cycle #(
      .AW     (AW),
      .STROBE (STROBE)
   ) u_cycle (
      .clk      (clk),
      .reset    (reset),
      .start    (cyc_start_reg),
      .wr       (cyc_wr_reg),
      .addr_in  (addr_reg),
      .wdata    (cyc_data_reg),
      .dq_in    (flash_dq_in),
      .addr_out (flash_addr),
      .dq_out   (flash_dq_out),
      .dq_oe    (flash_dq_oe),
      .ce_n     (flash_ce_n),
      .oe_n     (flash_oe_n),
      .we_n     (flash_we_n),
      .rdata    (cyc_rdata),
      .done     (cyc_done)
   );

   // Slave takes address and data together; byte strobes are not used
   assign wr_take = awvalid && awready && wvalid && wready;

   always_comb begin
      awready_next = awvalid && wvalid && !awready && !bvalid;
      wready_next = awvalid && wvalid && !wready && !bvalid;
      bvalid_next = bvalid;
      bresp_next = bresp;
      arready_next = arvalid && !arready && !rvalid;
      rvalid_next = rvalid;
      rresp_next = rresp;
      rdata_next = rdata;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      op_next = op_reg;
      go_next = 1'b0;
      abort_next = abort_reg && (st_reg != flash_poll_pkg::S_IDLE);
      if (bvalid && bready) begin
         bvalid_next = 1'b0;
      end
      if (wr_take) begin
         bvalid_next = 1'b1;
         bresp_next = `RESP_OKAY;
         case (awaddr)
            `CTRL_OFS: begin
               op_next = wdata[`CTRL_OP_LSB +: 2];
               go_next = wdata[`CTRL_GO_BIT];
               abort_next = abort_next || wdata[`CTRL_ABORT_BIT];
            end
            `ADDR_OFS: addr_next = wdata[AW-1:0];
            `WDATA_OFS: wdata_next = wdata[7:0];
            `STATUS_OFS: ;
            default: bresp_next = `RESP_DECERR;
         endcase
      end
      if (rvalid && rready) begin
         rvalid_next = 1'b0;
      end
      if (arvalid && arready) begin
         rvalid_next = 1'b1;
         rresp_next = `RESP_OKAY;
         case (araddr)
            `CTRL_OFS: rdata_next = {29'h0000_0000, op_reg, 1'b0};
            `ADDR_OFS: rdata_next = 32'(addr_reg);
            `WDATA_OFS: rdata_next = {24'h00_0000, wdata_reg};
            `STATUS_OFS: rdata_next = {16'h0000, last_reg, 3'h0, rb_reg, rej_reg,
                                       fail_reg, ok_reg, st_reg != flash_poll_pkg::S_IDLE};
            default: begin
               rdata_next = 32'h0000_0000;
               rresp_next = `RESP_DECERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rresp <= `RESP_OKAY;
         rdata <= 32'h0000_0000;
         addr_reg <= '0;
         wdata_reg <= 8'h00;
         op_reg <= `CTRL_RESET;
         go_reg <= 1'b0;
         abort_reg <= 1'b0;
      end else begin
         awready <= awready_next;
         wready <= wready_next;
         bvalid <= bvalid_next;
         bresp <= bresp_next;
         arready <= arready_next;
         rvalid <= rvalid_next;
         rresp <= rresp_next;
         rdata <= rdata_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         op_reg <= op_next;
         go_reg <= go_next;
         abort_reg <= abort_next;
      end
   end

   always_comb begin
      st_next = st_reg;
      cyc_start_next = 1'b0;
      cyc_wr_next = cyc_wr_reg;
      cyc_data_next = cyc_data_reg;
      first_next = first_reg;
      last_next = last_reg;
      ok_next = ok_reg;
      fail_next = fail_reg;
      rej_next = rej_reg;
      case (st_reg)
         flash_poll_pkg::S_IDLE: begin
            if (go_reg) begin
               ok_next = 1'b0;
               fail_next = 1'b0;
               rej_next = 1'b0;
               cyc_start_next = 1'b1;
               cyc_wr_next = 1'b0;
               cyc_data_next = wdata_reg;
               case (op_reg)
                  flash_poll_pkg::OP_WRITE: begin
                     cyc_wr_next = 1'b1;
                     st_next = flash_poll_pkg::S_SINGLE;
                  end
                  flash_poll_pkg::OP_READ: st_next = flash_poll_pkg::S_SINGLE;
                  // Every new poll begins with a fresh pair of reads
                  flash_poll_pkg::OP_POLL: st_next = flash_poll_pkg::S_RD1; // R21
                  default: st_next = flash_poll_pkg::S_EW_PRE;
               endcase
            end
         end
         flash_poll_pkg::S_SINGLE: begin
            if (cyc_done) begin
               last_next = cyc_rdata;
               ok_next = 1'b1;
               st_next = flash_poll_pkg::S_IDLE;
            end
         end
         flash_poll_pkg::S_RD1: begin
            if (cyc_done) begin
               first_next = cyc_rdata; // R19
               cyc_start_next = 1'b1;
               cyc_wr_next = 1'b0;
               st_next = flash_poll_pkg::S_RD2;
            end
         end
         flash_poll_pkg::S_RD2: begin
            if (cyc_done) begin
               last_next = cyc_rdata;
               first_next = cyc_rdata;
               if (cyc_rdata[`TOGGLE_BIT] == first_reg[`TOGGLE_BIT]) begin
                  ok_next = 1'b1; // R19
                  st_next = flash_poll_pkg::S_IDLE;
               end else if (cyc_rdata[`TIMEOUT_BIT]) begin
                  cyc_start_next = 1'b1; // R20
                  st_next = flash_poll_pkg::S_RD3;
               end else if (abort_reg) begin
                  st_next = flash_poll_pkg::S_IDLE; // R21
               end else begin
                  cyc_start_next = 1'b1;
               end
            end
         end
         flash_poll_pkg::S_RD3: begin
            if (cyc_done) begin
               last_next = cyc_rdata;
               if (cyc_rdata[`TOGGLE_BIT] == first_reg[`TOGGLE_BIT]) begin
                  ok_next = 1'b1;
                  st_next = flash_poll_pkg::S_IDLE;
               end else begin
                  cyc_start_next = 1'b1; // R13
                  cyc_wr_next = 1'b1;
                  cyc_data_next = RESET_CMD;
                  st_next = flash_poll_pkg::S_RST;
               end
            end
         end
         flash_poll_pkg::S_RST: begin
            if (cyc_done) begin
               fail_next = 1'b1; // R20
               st_next = flash_poll_pkg::S_IDLE;
            end
         end
         flash_poll_pkg::S_EW_PRE: begin
            if (cyc_done) begin
               last_next = cyc_rdata;
               // Window always checked, so command spacing never matters
               if (cyc_rdata[`WINDOW_BIT]) begin
                  rej_next = 1'b1; // R17
                  st_next = flash_poll_pkg::S_IDLE;
               end else begin
                  cyc_start_next = 1'b1; // R18
                  cyc_wr_next = 1'b1;
                  st_next = flash_poll_pkg::S_EW_CMD;
               end
            end
         end
         flash_poll_pkg::S_EW_CMD: begin
            if (cyc_done) begin
               cyc_start_next = 1'b1;
               cyc_wr_next = 1'b0;
               st_next = flash_poll_pkg::S_EW_POST;
            end
         end
         flash_poll_pkg::S_EW_POST: begin
            if (cyc_done) begin
               last_next = cyc_rdata;
               rej_next = cyc_rdata[`WINDOW_BIT]; // R18
               ok_next = !cyc_rdata[`WINDOW_BIT];
               st_next = flash_poll_pkg::S_IDLE;
            end
         end
         default: st_next = flash_poll_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= flash_poll_pkg::S_IDLE;
         cyc_start_reg <= 1'b0;
         cyc_wr_reg <= 1'b0;
         cyc_data_reg <= 8'h00;
         first_reg <= 8'h00;
         last_reg <= 8'h00;
         ok_reg <= 1'b0;
         fail_reg <= 1'b0;
         rej_reg <= 1'b0;
         rb_reg <= 1'b1;
      end else begin
         st_reg <= st_next;
         cyc_start_reg <= cyc_start_next;
         cyc_wr_reg <= cyc_wr_next;
         cyc_data_reg <= cyc_data_next;
         first_reg <= first_next;
         last_reg <= last_next;
         ok_reg <= ok_next;
         fail_reg <= fail_next;
         rej_reg <= rej_next;
         // Wired busy line is only sampled; pull-up lives on the board
         rb_reg <= ready_busy_n_out;
      end
   end

   property p_reset_cmd;
      @(posedge clk) disable iff (reset)
      $rose(fail_reg) |-> $past(st_reg) == flash_poll_pkg::S_RST && $past(cyc_done);
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("fail without reset write"); // R13

   property p_done_steady;
      @(posedge clk) disable iff (reset)
      (st_reg == flash_poll_pkg::S_RD2 && cyc_done
       && cyc_rdata[`TOGGLE_BIT] == first_reg[`TOGGLE_BIT])
      |=> ok_reg && st_reg == flash_poll_pkg::S_IDLE;
   endproperty
   a_done_steady: assert property (p_done_steady) else $error("steady toggle not done"); // R19

   property p_recheck;
      @(posedge clk) disable iff (reset)
      (st_reg == flash_poll_pkg::S_RD2 && cyc_done && cyc_rdata[`TIMEOUT_BIT]
       && cyc_rdata[`TOGGLE_BIT] != first_reg[`TOGGLE_BIT])
      |=> st_reg == flash_poll_pkg::S_RD3 ##1 !flash_ce_n;
   endproperty
   a_recheck: assert property (p_recheck) else $error("no recheck on timeout"); // R20

   property p_restart;
      @(posedge clk) disable iff (reset)
      (st_reg == flash_poll_pkg::S_IDLE && go_reg && op_reg == flash_poll_pkg::OP_POLL)
      |=> st_reg == flash_poll_pkg::S_RD1 ##1 !flash_ce_n && flash_we_n;
   endproperty
   a_restart: assert property (p_restart) else $error("poll not restarted at first read"); // R21

   property p_window_post;
      @(posedge clk) disable iff (reset)
      (st_reg == flash_poll_pkg::S_EW_POST && cyc_done)
      |=> rej_reg == $past(cyc_rdata[`WINDOW_BIT]) && st_reg == flash_poll_pkg::S_IDLE;
   endproperty
   a_window_post: assert property (p_window_post) else $error("post check lost"); // R18

   property p_window_pre;
      @(posedge clk) disable iff (reset)
      (st_reg == flash_poll_pkg::S_EW_PRE && cyc_done && cyc_rdata[`WINDOW_BIT])
      |=> rej_reg ##1 flash_we_n [*2];
   endproperty
   a_window_pre: assert property (p_window_pre) else $error("closed window written"); // R17
endmodule : flash_status_host
`default_nettype wire

/* design/flash_poll_cfg.svh */
// Operation
// R1: Busy line low during program or erase
// R2: Busy line is open-drain, externally pulled up
// R3: Busy line valid after final write strobe
// R4: Progress toggle readable anywhere, valid from command
// R5: Each read inverts progress toggle while busy
// R6: All-protected erase toggles about 100 us
// R7: Protected program address toggles about 2 us
// R8: Erase pause stops toggling; pause-program toggles
// R9: Sector toggle flips on reads in erased sectors
// R10: Pause reads elsewhere return array data
// R11: Timeout flag set when pulse limit exceeded
// R12: Programming 0 to 1 ends in timeout
// R13: Host writes reset command after timeout failure
// R14: Erase window flag 0 then 1 on start
// R15: Each added sector erase restarts window
// R16: Window closed ignores all but erase pause
// R17: Skip window check only if gaps under 50 us
// R18: Check window flag before and after each add
// R19: Two reads compared; unchanged toggle means done
// R20: Toggling with timeout set: recheck, then reset
// R21: Resumed polling restarts from two-read step
// R22: Poll flag shows complement until program ends
// R23: Device model times its intervals by counter
`ifndef FLASH_POLL_CFG_SVH
`define FLASH_POLL_CFG_SVH
`define CTRL_OFS 5'h00
`define ADDR_OFS 5'h04
`define WDATA_OFS 5'h08
`define STATUS_OFS 5'h0C
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 1
`define CTRL_ABORT_BIT 3
`define CTRL_RESET 2'h0
`define TOGGLE_BIT 6
`define TIMEOUT_BIT 5
`define WINDOW_BIT 3
`define CLK_MHZ 40
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

/* design/flash_poll_pkg.sv */
package flash_poll_pkg;
   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_READ  = 2'b01,
      OP_POLL  = 2'b10,
      OP_EWADD = 2'b11
   } op_e;
   typedef enum logic [3:0] {
      S_IDLE    = 4'b0000,
      S_SINGLE  = 4'b0001,
      S_RD1     = 4'b0010,
      S_RD2     = 4'b0011,
      S_RD3     = 4'b0100,
      S_RST     = 4'b0101,
      S_EW_PRE  = 4'b0110,
      S_EW_CMD  = 4'b0111,
      S_EW_POST = 4'b1000
   } state_e;
endpackage : flash_poll_pkg

/* design/flash_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_cycle #(
   parameter int AW     = 19,
   parameter int STROBE = 4
) (
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic          start,
   input  wire logic          wr,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [7:0]    wdata,
   input  wire logic [7:0]    dq_in,
   output logic     [AW-1:0]  addr_out,
   output logic     [7:0]     dq_out,
   output logic               dq_oe,
   output logic               ce_n,
   output logic               oe_n,
   output logic               we_n,
   output logic     [7:0]     rdata,
   output logic               done
);
   logic [7:0]    cnt_reg, cnt_next;
   logic          act_reg, act_next, wr_reg, wr_next;
   logic          ce_next, oe_next, we_next, oe_q_next, done_next;
   logic [AW-1:0] addr_next;
   logic [7:0]    dout_next, rdata_next;

   always_comb begin
      cnt_next = cnt_reg;
      act_next = act_reg;
      wr_next = wr_reg;
      ce_next = ce_n;
      oe_next = oe_n;
      we_next = we_n;
      oe_q_next = dq_oe;
      addr_next = addr_out;
      dout_next = dq_out;
      rdata_next = rdata;
      done_next = 1'b0;
      if (!act_reg) begin
         if (start) begin
            act_next = 1'b1;
            cnt_next = 8'h00;
            wr_next = wr;
            ce_next = 1'b0;
            addr_next = addr_in;
            dout_next = wdata;
            oe_q_next = wr;
         end
      end else begin
         cnt_next = cnt_reg + 8'h01;
         if (cnt_reg == 8'h00) begin
            oe_next = wr_reg;
            we_next = !wr_reg;
         end else if (cnt_reg == 8'(STROBE)) begin
            // Data lives on the bus until the write strobe has risen
            oe_next = 1'b1;
            we_next = 1'b1;
            if (!wr_reg) begin
               rdata_next = dq_in;
            end
         end else if (cnt_reg == 8'(STROBE + 1)) begin
            ce_next = 1'b1;
            oe_q_next = 1'b0;
            act_next = 1'b0;
            done_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= 8'h00;
         act_reg <= 1'b0;
         wr_reg <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         dq_oe <= 1'b0;
         addr_out <= '0;
         dq_out <= 8'h00;
         rdata <= 8'h00;
         done <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         act_reg <= act_next;
         wr_reg <= wr_next;
         ce_n <= ce_next;
         oe_n <= oe_next;
         we_n <= we_next;
         dq_oe <= oe_q_next;
         addr_out <= addr_next;
         dq_out <= dout_next;
         rdata <= rdata_next;
         done <= done_next;
      end
   end
endmodule : flash_cycle
`default_nettype wire

/* bench/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
   input  wire logic [18:0] addr,
   input  wire logic [7:0]  dq_host,
   input  wire logic        dq_oe,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   output logic      [7:0]  dq_dev,
   output wire logic        ready_busy_n
);
   logic [7:0] mem [0:255];
   logic [7:0] last;
   logic [7:0] rd_val;
   logic       status_mode;
   logic       erase;
   logic       fail;
   logic       window;
   logic       close_on_add;
   logic       tog;
   logic       stog;
   logic       pause;
   int         toggles_left;
   int         adds;
   int         resets;
   initial begin
      last = 8'h00;
      status_mode = 1'b0;
      erase = 1'b0;
      fail = 1'b0;
      window = 1'b0;
      close_on_add = 1'b0;
      tog = 1'b0;
      stog = 1'b0;
      pause = 1'b0;
      toggles_left = 0;
      adds = 0;
      resets = 0;
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
   end
   // Bench starts an operation; -1 reads toggle until a reset command
   task automatic start(input int n, input bit e, input bit f, input bit w);
      status_mode = 1'b1;
      erase = e;
      fail = f;
      window = w;
      toggles_left = n;
   endtask : start
   // Poll flag reads low during any unpaused operation, erase or program alike
   always @* begin
      if (status_mode && !pause) begin
         rd_val = {1'b0, tog, fail, 1'b0, window, erase & stog, 2'b00};
      end else begin
         rd_val = mem[addr[7:0]];
      end
   end
   // Released bus shows the inverse of the last value, never a stale match
   assign dq_dev = (!ce_n && !oe_n) ? rd_val : ~last;
   // Open drain: pulled up by the bench while no operation runs
   assign ready_busy_n = (status_mode && !pause) ? 1'b0 : 1'bz;
   always @(posedge oe_n) begin
      if (!ce_n) begin
         last = rd_val;
         // Pause freezes the progress flag; sector flag keeps flipping
         if (status_mode && erase) stog = ~stog;
         if (status_mode && !pause) begin
            tog = ~tog;
            // Read count stands in for the timed protected-sector spans
            if (toggles_left > 0) begin
               toggles_left -= 1;
               if (toggles_left == 0) status_mode = 1'b0;
            end
         end
      end
   end
   always @(posedge we_n) begin
      if (!ce_n && dq_oe) begin
         if (status_mode && dq_host == 8'hF0) begin
            status_mode = 1'b0;
            fail = 1'b0;
            resets += 1;
         end else if (status_mode && erase && dq_host == 8'h30) begin
            // Closed window ignores further adds; open one counts it and closes if close_on_add
            if (!window) begin
               adds += 1;
               if (close_on_add) window = 1'b1;
            end
         end else if (!status_mode) mem[addr[7:0]] = dq_host;
      end
   end
endmodule : flash_dev_model
`default_nettype wire

/* bench/flash_status_host_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_poll_cfg.svh"
module flash_status_host_bench;
   logic        clk;
   logic        reset;
   logic [4:0]  awaddr;
   logic [4:0]  araddr;
   logic        awvalid;
   logic        wvalid;
   logic        bready;
   logic        arvalid;
   logic        rready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        awready;
   logic        wready;
   logic        bvalid;
   logic        arready;
   logic        rvalid;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic [31:0] rdata;
   logic [18:0] flash_addr;
   logic [7:0]  flash_dq_out;
   logic [7:0]  flash_dq_in;
   logic        flash_dq_oe;
   logic        flash_ce_n;
   logic        flash_oe_n;
   logic        flash_we_n;
   tri1         rb_n;
   int          miscompares;
   int          samples_checked;
   logic [31:0] rd;
   logic [1:0]  rs;
   flash_status_host DUT (
      .clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .ready_busy_n_out(rb_n));
   flash_dev_model dev (
      .addr(flash_addr), .dq_host(flash_dq_out), .dq_oe(flash_dq_oe), .ce_n(flash_ce_n),
      .oe_n(flash_oe_n), .we_n(flash_we_n), .dq_dev(flash_dq_in), .ready_busy_n(rb_n));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      axi_write(a, d, rs);
      check({30'h0, rs}, {30'h0, `RESP_OKAY});
   endtask : wr
   // Write CTRL unless zero, then poll status until the sequencer is idle again
   task automatic op_run(input logic [31:0] ctrl);
      int n;
      if (ctrl != 32'h0) wr(`CTRL_OFS, ctrl);
      repeat (3) @(posedge clk);
      n = 0;
      do begin
         axi_read(`STATUS_OFS, rd, rs);
         n++;
      end while (rd[0] !== 1'b0 && n < 300);
      // A poll that never goes idle is a mismatch, not a silent pass
      check({31'h0, rd[0]}, 32'h0000_0000);
   endtask : op_run
   initial begin
      miscompares = 0;
      samples_checked = 0;
      reset = 1'b1;
      {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      axi_read(5'h10, rd, rs);
      check({30'h0, rs}, {30'h0, `RESP_DECERR});
      check(rd, 32'h0000_0000);
      axi_write(5'h14, 32'h0000_0001, rs);
      check({30'h0, rs}, {30'h0, `RESP_DECERR});
      axi_read(`STATUS_OFS, rd, rs);
      check({27'h0, rd[4:0]}, 32'h0000_0010);
      $display("test registers done");
      wr(`ADDR_OFS, 32'h0000_0012);
      wr(`WDATA_OFS, 32'h0000_005A);
      op_run(32'h0000_0001);
      op_run(32'h0000_0003);
      check({24'h0, rd[15:8]}, 32'h0000_005A);
      axi_read(`CTRL_OFS, rd, rs);
      check({30'h0, rd[2:1]}, 32'h0000_0001);
      $display("test single cycles done");
      dev.start(5, 1'b0, 1'b0, 1'b0);
      @(posedge clk);
      check({31'h0, rb_n}, 32'h0000_0000);
      axi_read(`STATUS_OFS, rd, rs);
      check({31'h0, rd[4]}, 32'h0000_0000);
      op_run(32'h0000_0005);
      check({28'h0, rd[3:0]}, 32'h0000_0002);
      check(dev.toggles_left, 0);
      check({31'h0, rb_n}, 32'h0000_0001);
      $display("test poll done");
      dev.start(-1, 1'b0, 1'b1, 1'b0);
      op_run(32'h0000_0005);
      check({28'h0, rd[3:0]}, 32'h0000_0004);
      check(dev.resets, 1);
      check({31'h0, rb_n}, 32'h0000_0001);
      $display("test timeout done");
      wr(`WDATA_OFS, 32'h0000_0030);
      dev.start(-1, 1'b1, 1'b0, 1'b0);
      op_run(32'h0000_0007);
      check({28'h0, rd[3:0]}, 32'h0000_0002);
      check(dev.adds, 1);
      dev.window = 1'b1;
      op_run(32'h0000_0007);
      check({28'h0, rd[3:0]}, 32'h0000_0008);
      check(dev.adds, 1);
      dev.window = 1'b0;
      dev.close_on_add = 1'b1;
      op_run(32'h0000_0007);
      check({28'h0, rd[3:0]}, 32'h0000_0008);
      check(dev.adds, 2);
      $display("test erase add done");
      dev.pause = 1'b1;
      @(posedge clk);
      check({31'h0, rb_n}, 32'h0000_0001);
      op_run(32'h0000_0005);
      check({28'h0, rd[3:0]}, 32'h0000_0002);
      check({24'h0, rd[15:8]}, 32'h0000_005A);
      dev.pause = 1'b0;
      $display("test pause done");
      dev.close_on_add = 1'b0;
      dev.start(-1, 1'b0, 1'b0, 1'b0);
      wr(`CTRL_OFS, 32'h0000_0005);
      repeat (40) @(posedge clk);
      op_run(32'h0000_0008);
      check({28'h0, rd[3:0]}, 32'h0000_0000);
      wr(`WDATA_OFS, 32'h0000_00F0);
      op_run(32'h0000_0001);
      check({31'h0, rb_n}, 32'h0000_0001);
      $display("test abort done");
      finish_test();
   end
   // Whole sequence needs a few hundred cycles; this bound is generous
   initial begin
      #(25 * 40000);
      miscompares++;
      finish_test();
   end
endmodule : flash_status_host_bench
`default_nettype wire
